// File: rtl/febs_pkg.sv
// febs_pkg: constants, types and command tables of the flash erase/bypass sequencer host.
// assumes one 40 MHz clock and a byte-wide flash behind the pin cycle engine.
`default_nettype none
package febs_pkg;
  localparam int unsigned CLK_NS          = 25;
  localparam int unsigned T_STROBE_NS     = 50;
  localparam int unsigned STROBE_CYC      = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_RESET_NS      = 500;
  localparam int unsigned RESET_CYC       = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_BUSY_NS       = 500;
  localparam int unsigned BUSY_CYC        = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_SECT_TO_US    = 50;
  localparam int unsigned SECT_TO_CYC     = (T_SECT_TO_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_ADD_LIMIT_US  = 40;
  localparam int unsigned ADD_CYC         = (T_ADD_LIMIT_US * 1000) / CLK_NS;
  localparam int unsigned T_SUSP_US       = 20;
  localparam int unsigned SUSP_CYC        = (T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  localparam logic [19:0] ADDR_RST  = 20'h00000;
  localparam logic [7:0]  DATA_RST  = 8'h00;

  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_BYP  = 1;
  localparam int unsigned ST_CHIP = 2;
  localparam int unsigned ST_WIN  = 3;
  localparam int unsigned ST_SECT = 4;
  localparam int unsigned ST_SUSP = 5;
  localparam int unsigned ST_ERR  = 6;
  localparam int unsigned ST_RDY  = 7;
  localparam int unsigned ST_ABRT = 8;

  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_BYPASS  = 8'h20;
  localparam logic [7:0] CMD_PROG    = 8'hA0;
  localparam logic [7:0] CMD_BYP_X1  = 8'h90;
  localparam logic [7:0] CMD_BYP_X2  = 8'h00;
  localparam logic [7:0] CMD_SETUP   = 8'h80;
  localparam logic [7:0] CMD_CHIP    = 8'h10;
  localparam logic [7:0] CMD_SECT    = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME  = 8'h30;
  localparam logic [7:0] CMD_RESET   = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_READ = 4'h1, OP_BYP_ENTER = 4'h2, OP_BYP_PROG = 4'h3,
    OP_BYP_EXIT = 4'h4, OP_CHIP = 4'h5, OP_SECT = 4'h6, OP_SECT_ADD = 4'h7,
    OP_SUSPEND = 4'h8, OP_RESUME = 4'h9, OP_RESET = 4'hA, OP_AUTOSEL = 4'hB,
    OP_HWRST = 4'hC
  } febs_op_t;

  typedef enum logic [1:0] {CK_WRITE = 2'b00, CK_READ = 2'b01, CK_HWRST = 2'b10} febs_kind_t;

  typedef struct packed {
    febs_kind_t  kind;
    logic [19:0] addr;
    logic [7:0]  data;
  } febs_req_t;

  typedef struct packed {
    logic        reset_n;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe;
    logic [7:0]  dq_o;
    logic [19:0] addr;
  } febs_pins_t;

  function automatic logic [2:0] febs_seq_len(input febs_op_t op);
    case (op)
      OP_BYP_ENTER, OP_AUTOSEL: return 3'd3;
      OP_BYP_PROG, OP_BYP_EXIT: return 3'd2;
      OP_CHIP, OP_SECT:         return 3'd6;
      default:                  return 3'd1;
    endcase
  endfunction : febs_seq_len

  function automatic logic [7:0] febs_seq_byte(input febs_op_t op, input logic [2:0] idx, input logic [7:0] pd);
    logic [7:0] b;
    b = (idx == 3'd0 || idx == 3'd3) ? CMD_UNLOCK1 : CMD_UNLOCK2;
    case (op)
      OP_BYP_ENTER: if (idx == 3'd2) b = CMD_BYPASS;
      OP_AUTOSEL:   if (idx == 3'd2) b = CMD_AUTOSEL;
      OP_BYP_PROG:  b = (idx == 3'd0) ? CMD_PROG : pd;
      OP_BYP_EXIT:  b = (idx == 3'd0) ? CMD_BYP_X1 : CMD_BYP_X2;
      OP_CHIP:      if (idx == 3'd2) b = CMD_SETUP; else if (idx == 3'd5) b = CMD_CHIP;
      OP_SECT:      if (idx == 3'd2) b = CMD_SETUP; else if (idx == 3'd5) b = CMD_SECT;
      OP_SECT_ADD:  b = CMD_SECT;
      OP_SUSPEND:   b = CMD_SUSPEND;
      OP_RESUME:    b = CMD_RESUME;
      OP_RESET:     b = CMD_RESET;
      default:      b = pd;
    endcase
    return b;
  endfunction : febs_seq_byte
endpackage : febs_pkg
`default_nettype wire

// File: rtl/febs_bus_cycle.sv
// febs_bus_cycle: runs one flash pin cycle (write, read or hardware reset pulse) per request.
// assumes the flash answers reads within one strobe phase; strobe and reset pins idle high between cycles.
`default_nettype none
module febs_bus_cycle
  import febs_pkg::*;
#(
  parameter int unsigned PHASE_CYC = STROBE_CYC,
  parameter int unsigned RST_CYC   = RESET_CYC
)(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           go,
  input  wire febs_pkg::febs_req_t req,
  input  wire logic [7:0]     dq_i,
  output logic                done,
  output logic [7:0]          rd_data,
  output febs_pkg::febs_pins_t pins
);
  import febs_pkg::*;
  if (PHASE_CYC < 1 || PHASE_CYC > 255 || RST_CYC < 1 || RST_CYC > 255)
    $error("febs_bus_cycle: phase counts out of range");

  typedef enum logic [1:0] {CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b10, CY_HOLD = 2'b11} febs_cy_t;
  localparam febs_pins_t PINS_IDLE = '{reset_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                       dq_oe: 1'b0, dq_o: 8'h00, addr: 20'h00000};
  febs_cy_t   st_q, st_d;
  logic [7:0] cnt_q, cnt_d, rd_q, rd_d;
  logic       done_q, done_d;
  febs_req_t  req_q, req_d;
  febs_pins_t pins_q, pins_d;

  always_comb
  begin
    st_d = st_q; cnt_d = cnt_q; rd_d = rd_q; req_d = req_q; pins_d = pins_q; done_d = 1'b0;
    case (st_q)
      CY_IDLE:
        if (go)
        begin
          req_d = req;
          cnt_d = 8'(PHASE_CYC - 1);
          st_d  = CY_SETUP;
          // address is set as ce falls, a setup phase before we falls, so the later falling edge latches it [R22]
          pins_d.addr  = req.addr;
          pins_d.dq_o  = req.data;
          pins_d.dq_oe = (req.kind == CK_WRITE);
          pins_d.ce_n  = (req.kind == CK_HWRST);
        end
      CY_SETUP:
        if (cnt_q == 8'h00)
        begin
          st_d  = CY_STROBE;
          cnt_d = (req_q.kind == CK_HWRST) ? 8'(RST_CYC - 1) : 8'(PHASE_CYC - 1);
          pins_d.we_n    = (req_q.kind != CK_WRITE);
          pins_d.oe_n    = (req_q.kind != CK_READ);
          pins_d.reset_n = (req_q.kind != CK_HWRST);
        end
        else cnt_d = cnt_q - 8'h01;
      CY_STROBE:
        if (cnt_q == 8'h00)
        begin
          st_d  = CY_HOLD;
          cnt_d = 8'(PHASE_CYC - 1);
          if (req_q.kind == CK_READ) rd_d = dq_i;
          // we rises while data is still driven: data is latched on that earlier rising edge [R22]
          pins_d.we_n = 1'b1;
          pins_d.oe_n = 1'b1;
          pins_d.reset_n = 1'b1;
        end
        else cnt_d = cnt_q - 8'h01;
      CY_HOLD:
        if (cnt_q == 8'h00)
        begin
          st_d   = CY_IDLE;
          pins_d = PINS_IDLE;
          done_d = 1'b1;
        end
        else cnt_d = cnt_q - 8'h01;
      default: st_d = CY_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= CY_IDLE; cnt_q <= 8'h00; rd_q <= 8'h00; done_q <= 1'b0;
      req_q <= '0; pins_q <= PINS_IDLE;
    end
    else
    begin
      st_q <= st_d; cnt_q <= cnt_d; rd_q <= rd_d; done_q <= done_d;
      req_q <= req_d; pins_q <= pins_d;
    end
  end

  assign done    = done_q;
  assign rd_data = rd_q;
  assign pins    = pins_q;
endmodule : febs_bus_cycle
`default_nettype wire

// File: rtl/febs_ctrl.sv
// febs_ctrl: host controller that drives a byte-wide flash's command state machine from AXI4-Lite.
// assumes the flash pins are wired straight to the pin struct; ready_busy_pin is high when ready.
// Functional notes
// [R1] bypass entry is two unlock writes then 20h
// [R2] bypass program is A0h then address with data, repeatable
// [R3] in bypass mode only bypass program and bypass exit are valid
// [R4] bypass exit writes 90h then 00h, back to array read
// [R5] chip erase is six writes ending in 10h, last starts erase
// [R6] the flash preprograms and verifies internally; host supplies no timing
// [R7] the flash ignores every command during chip erase
// [R8] hardware reset aborts erase; host must reissue erase afterwards
// [R9] erase completion returns the flash to array read
// [R10] sector erase is six writes, last carries sector address and 30h
// [R11] a 50 us window after the last strobe accepts further sectors
// [R12] host spaces extra sector commands under 50 us apart
// [R13] other commands in the window return to array read; rewrite all
// [R14] an erase timer bit shows whether the window has expired
// [R15] once sector erase runs only suspend is valid
// [R16] suspend is valid only in sector erase or its window
// [R17] suspend takes at most 20 us, immediate within the window
// [R18] suspended flash allows reads and programs outside erasing sectors; febs_legal allows reads but refuses programs while suspended
// [R19] autoselect works during suspend and returns to suspend
// [R20] resume continues erase; repeats ignored; later suspend allowed again
// [R21] erase progress shows on polling, toggle bits and ready_busy_pin
// [R22] address latches on later falling strobe, data on earlier rising
// [R23] sector chosen by top seven address bits
// [R24] codes AAh, 55h, 80h, 10h, 30h, B0h, resume 30h
// [R25] departures from valid sequences return the flash to array read
`default_nettype none
module febs_ctrl
  import febs_pkg::*;
#(
  parameter int unsigned SECT_TO  = SECT_TO_CYC,
  parameter int unsigned ADD_LIM  = ADD_CYC,
  parameter int unsigned SUSP_MAX = SUSP_CYC
)(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  input  wire logic [7:0]      araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  input  wire logic [7:0]      fl_dq_i,
  input  wire logic            ready_busy_pin,
  output febs_pkg::febs_pins_t fl_pins
);
  import febs_pkg::*;
  if (ADD_LIM >= SECT_TO || SECT_TO > 4095 || SUSP_MAX < 1 || SUSP_MAX > 1000 || BUSY_CYC >= SUSP_MAX)
    $error("febs_ctrl: timing parameters out of range");

  typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_ISSUE = 2'b01, CS_WAIT = 2'b10, CS_SUSP = 2'b11} febs_cs_t;

  // ---------------- register bus ----------------
  logic        awready_q, awready_d, arready_q, arready_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [19:0] addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic        wr_take, rd_take, start, err_clr;
  febs_op_t    start_op;
  logic [8:0]  status;
  logic [7:0]  rd_byte;
  logic [31:0] wmask;

  function automatic logic [31:0] febs_wmask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : febs_wmask

  assign wr_take  = awready_q && awvalid && wvalid;
  assign rd_take  = arready_q && arvalid;
  assign start    = wr_take && awaddr == OFS_CTRL && wstrb[0];
  assign start_op = febs_op_t'(wdata[3:0]);
  assign err_clr  = wr_take && awaddr == OFS_STATUS && wstrb[0] && wdata[ST_ERR];
  assign wmask    = febs_wmask(wstrb);

  always_comb
  begin
    awready_d = awvalid && wvalid && !bvalid_q && !awready_q;
    arready_d = arvalid && !rvalid_q && !arready_q;
    bvalid_d = bvalid_q && !bready; bresp_d = bresp_q;
    rvalid_d = rvalid_q && !rready; rresp_d = rresp_q; rdata_d = rdata_q;
    addr_d = addr_q; data_d = data_q;
    if (wr_take)
    begin
      bvalid_d = 1'b1;
      bresp_d  = 2'b00;
      case (awaddr)
        OFS_ADDR:   addr_d = (addr_q & ~wmask[19:0]) | (wdata[19:0] & wmask[19:0]);
        OFS_DATA:   if (wstrb[0]) data_d = wdata[7:0];
        OFS_CTRL, OFS_STATUS: ;
        default:    bresp_d = 2'b10;
      endcase
    end
    if (rd_take)
    begin
      rvalid_d = 1'b1;
      rresp_d  = 2'b00;
      case (araddr)
        OFS_CTRL:   rdata_d = 32'h00000000;
        OFS_ADDR:   rdata_d = {12'h000, addr_q};
        OFS_DATA:   rdata_d = {24'h000000, data_q};
        OFS_STATUS: rdata_d = {23'h000000, status};
        OFS_RDATA:  rdata_d = {24'h000000, rd_byte};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0; arready_q <= 1'b0; bvalid_q <= 1'b0; rvalid_q <= 1'b0;
      bresp_q <= 2'b00; rresp_q <= 2'b00; rdata_q <= 32'h00000000;
      addr_q <= ADDR_RST; data_q <= DATA_RST;
    end
    else
    begin
      awready_q <= awready_d; arready_q <= arready_d; bvalid_q <= bvalid_d; rvalid_q <= rvalid_d;
      bresp_q <= bresp_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
      addr_q <= addr_d; data_q <= data_d;
    end
  end

  assign awready = awready_q;
  assign wready  = awready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  // ---------------- command sequencer ----------------
  febs_cs_t   cs_q, cs_d;
  febs_op_t   op_q, op_d;
  logic [2:0] idx_q, idx_d;
  logic [11:0] tmr_q, tmr_d;
  logic       go_q, go_d, byp_q, byp_d, chip_q, chip_d, win_q, win_d, sect_q, sect_d;
  logic       susp_q, susp_d, err_q, err_d, abrt_q, abrt_d;
  febs_req_t  req_q, req_d;
  logic       cyc_done, seq_end;

  // host-side view of which commands the flash will honour in its present mode
  function automatic logic febs_legal(input febs_op_t op, input logic byp, input logic chip,
                                      input logic win, input logic sect, input logic susp,
                                      input logic [11:0] tmr);
    if (op == OP_HWRST || op == OP_READ) return 1'b1;
    if (byp)  return op == OP_BYP_PROG || op == OP_BYP_EXIT;                   // [R3]
    if (chip) return 1'b0;                                                    // [R7] [R16]
    if (win)  return op == OP_SUSPEND || op == OP_RESET ||
                     (op == OP_SECT_ADD && tmr < 12'(ADD_LIM));               // [R12] [R13]
    if (sect) return op == OP_SUSPEND;                                        // [R15]
    if (susp) return op == OP_RESUME || op == OP_AUTOSEL || op == OP_RESET;   // [R19] [R20]
    return !(op inside {OP_NONE, OP_SECT_ADD, OP_SUSPEND, OP_RESUME, OP_BYP_PROG, OP_BYP_EXIT});
  endfunction : febs_legal

  assign seq_end = cs_q == CS_WAIT && cyc_done && idx_q == febs_seq_len(op_q) - 3'd1;
  assign status  = {abrt_q, ready_busy_pin, err_q, susp_q, sect_q, win_q, chip_q, byp_q, cs_q != CS_IDLE};

  always_comb
  begin
    cs_d = cs_q; op_d = op_q; idx_d = idx_q; go_d = 1'b0; req_d = req_q;
    byp_d = byp_q; chip_d = chip_q; win_d = win_q; sect_d = sect_q; susp_d = susp_q;
    abrt_d = abrt_q;
    err_d = err_q && !err_clr;
    tmr_d = (tmr_q == 12'hFFF) ? tmr_q : tmr_q + 12'h001;
    // the window closes on its own; erase then runs until the flash reports ready [R11] [R14]
    if (win_q && tmr_q >= 12'(SECT_TO - 1))
    begin
      win_d  = 1'b0;
      sect_d = 1'b1;
      tmr_d  = 12'h000;
    end
    // ready_busy_pin is ignored for a short guard so the flash has time to go busy [R9] [R21]
    // a reset pulse frees ready_busy_pin early; that must count as an abort, not completion [R8]
    if ((chip_q || (sect_q && cs_q != CS_SUSP)) && tmr_q >= 12'(BUSY_CYC) && ready_busy_pin &&
        !(cs_q != CS_IDLE && op_q == OP_HWRST))
    begin
      chip_d = 1'b0;
      sect_d = 1'b0;
    end
    case (cs_q)
      CS_IDLE:
        if (start)
        begin
          if (febs_legal(start_op, byp_q, chip_q, win_q, sect_q, susp_q, tmr_q))
          begin
            op_d  = start_op;
            idx_d = 3'd0;
            cs_d  = CS_ISSUE;
          end
          else err_d = 1'b1;
        end
      CS_ISSUE:
      begin
        go_d       = 1'b1;
        req_d.kind = (op_q == OP_READ) ? CK_READ : (op_q == OP_HWRST) ? CK_HWRST : CK_WRITE;
        req_d.data = febs_seq_byte(op_q, idx_q, data_q);                      // [R24]
        // only the final cycle of each command carries the target address; earlier cycles drive address 0 [R23]
        req_d.addr = (idx_q == febs_seq_len(op_q) - 3'd1) ? addr_q : 20'h00000;
        cs_d       = CS_WAIT;
      end
      CS_WAIT:
        if (cyc_done)
        begin
          idx_d = idx_q + 3'd1;
          cs_d  = seq_end ? CS_IDLE : CS_ISSUE;
          if (seq_end)
            case (op_q)
              OP_BYP_ENTER: byp_d = 1'b1;                                     // [R1]
              OP_BYP_EXIT:  byp_d = 1'b0;                                     // [R4]
              OP_CHIP:                                                        // [R5] [R6]
              begin
                chip_d = 1'b1;
                tmr_d  = 12'h000;
              end
              OP_SECT, OP_SECT_ADD:                                           // [R10] [R11]
              begin
                win_d = 1'b1;
                tmr_d = 12'h000;
              end
              OP_SUSPEND:
                if (win_q)
                begin
                  win_d  = 1'b0;                                              // [R17]
                  sect_d = 1'b0;
                  susp_d = 1'b1;
                end
                else
                begin
                  tmr_d = 12'h000;
                  cs_d  = CS_SUSP;
                end
              OP_RESUME:                                                      // [R20]
              begin
                susp_d = 1'b0;
                sect_d = 1'b1;
                tmr_d  = 12'h000;
              end
              OP_RESET: win_d = 1'b0;                                         // [R13] [R25]
              OP_HWRST:                                                       // [R8]
              begin
                abrt_d = abrt_q || chip_q || win_q || sect_q || susp_q;
                byp_d  = 1'b0;
                chip_d = 1'b0;
                win_d  = 1'b0;
                sect_d = 1'b0;
                susp_d = 1'b0;
              end
              default: ;
            endcase
        end
      CS_SUSP:
        if (tmr_q >= 12'(SUSP_MAX - 1))
        begin
          sect_d = 1'b0;
          susp_d = 1'b1;
          cs_d   = CS_IDLE;
        end
      default: cs_d = CS_IDLE;
    endcase
    if (start && cs_q != CS_IDLE) err_d = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_q <= CS_IDLE; op_q <= OP_NONE; idx_q <= 3'd0; go_q <= 1'b0; req_q <= '0; tmr_q <= 12'h000;
      byp_q <= 1'b0; chip_q <= 1'b0; win_q <= 1'b0; sect_q <= 1'b0; susp_q <= 1'b0;
      err_q <= 1'b0; abrt_q <= 1'b0;
    end
    else
    begin
      cs_q <= cs_d; op_q <= op_d; idx_q <= idx_d; go_q <= go_d; req_q <= req_d; tmr_q <= tmr_d;
      byp_q <= byp_d; chip_q <= chip_d; win_q <= win_d; sect_q <= sect_d; susp_q <= susp_d;
      err_q <= err_d; abrt_q <= abrt_d;
    end
  end

  febs_bus_cycle u_cycle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .go      (go_q),
    .req     (req_q),
    .dq_i    (fl_dq_i),
    .done    (cyc_done),
    .rd_data (rd_byte),
    .pins    (fl_pins)
  );

  // ---------------- checks ----------------
  localparam int SUSP_BOUND = int'(SUSP_MAX);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_bypass_refuse: assert property (start && byp_q && cs_q == CS_IDLE &&    // [R3]
      !(start_op inside {OP_BYP_PROG, OP_BYP_EXIT, OP_READ, OP_HWRST}) |=> cs_q == CS_IDLE && err_q)
    else $error("illegal command accepted in bypass mode");
  chk_bypass_enter: assert property (seq_end && op_q == OP_BYP_ENTER |=> byp_q)  // [R1]
    else $error("bypass mode not entered");
  chk_bypass_exit: assert property (seq_end && op_q == OP_BYP_EXIT |=> !byp_q)   // [R4]
    else $error("bypass mode not left");
  chk_chip_quiet: assert property (go_q && chip_q |-> req_q.kind != CK_WRITE)    // [R7]
    else $error("command written during chip erase");
  chk_sect_only_susp: assert property (go_q && sect_q && req_q.kind == CK_WRITE |-> // [R15]
      req_q.data == CMD_SUSPEND || op_q == OP_RESUME)
    else $error("non-suspend command during sector erase");
  chk_susp_scope: assert property (go_q && op_q == OP_SUSPEND |-> win_q || sect_q) // [R16]
    else $error("suspend outside sector erase");
  chk_susp_bound: assert property ($rose(cs_q == CS_SUSP) |-> ##[1:SUSP_BOUND] susp_q) // [R17]
    else $error("suspend not reached in time");
  chk_add_spacing: assert property (go_q && op_q == OP_SECT_ADD |-> win_q && tmr_q < 12'(ADD_LIM)) // [R12]
    else $error("sector add issued too late");
  chk_window_len: assert property (win_q |-> tmr_q < 12'(SECT_TO))             // [R11]
    else $error("sector window overran");
  chk_hwrst_clear: assert property (seq_end && op_q == OP_HWRST |=>            // [R8]
      !(byp_q || chip_q || win_q || sect_q || susp_q))
    else $error("state kept across hardware reset");
  chk_chip_len: assert property (go_q && op_q == OP_CHIP && idx_q == 3'd5 |-> req_q.data == CMD_CHIP) // [R5]
    else $error("chip erase final byte wrong");

  cov_bypass_prog: cover property (seq_end && op_q == OP_BYP_PROG && byp_q);
  cov_sect_add:    cover property (seq_end && op_q == OP_SECT_ADD);
  cov_suspend:     cover property (susp_q ##1 seq_end && op_q == OP_RESUME);
  cov_chip_done:   cover property ($fell(chip_q));
endmodule : febs_ctrl
`default_nettype wire

// File: dv/febs_flash_model.sv
// febs_flash_model: behavioural byte-wide flash on the far side of febs_ctrl's pins.
// assumes pins come straight from the controller; aclk samples the write strobe and times the busy span.
`default_nettype none
module febs_flash_model
  import febs_pkg::*;
(
  input  wire logic            aclk,
  input  wire febs_pkg::febs_pins_t pins,
  output logic [7:0]           dq,
  output logic                 rb
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [47:0] hist = '0;
  logic [6:0]  sect_sel = '0;
  logic [7:0]  last = '0;
  logic        we_q = 1'b1;
  int          busy = 0;
  assign rb = (busy == 0);
  // a released bus shows the inverse of the last byte so stale data cannot pass
  assign dq = (!pins.ce_n && !pins.oe_n) ? ((busy != 0) ? 8'h00 : 8'h5A) : ~last;
  always @(posedge aclk)
  begin
    we_q <= pins.we_n;
    last <= dq;
    if (!pins.reset_n)
      busy <= 0;
    else if (busy != 0)
      busy <= busy - 1;
    if (!we_q && pins.we_n && !pins.ce_n && pins.reset_n && busy == 0)
    begin
      hist <= {hist[39:0], pins.dq_o};
      if (hist[23:0] == 24'h80AA55 && (pins.dq_o == 8'h10 || pins.dq_o == 8'h30))
      begin
        busy <= 400;
        sect_sel <= pins.addr[19:13];
      end
    end
  end
endmodule : febs_flash_model
`default_nettype wire

// File: dv/tb_flash_erase_bypass_sequencer.sv
// tb_flash_erase_bypass_sequencer: drives febs_ctrl over AXI4-Lite against the flash model.
// assumes sim-sized window, add and suspend counts set at the instance.
`default_nettype none
module tb_flash_erase_bypass_sequencer
  import febs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rb;
  logic [7:0] awaddr = '0, araddr = '0, dq;
  logic [31:0] wdata = '0, rdata, rv;
  logic [1:0] bresp, rresp, rr;
  febs_pins_t pins;
  int bad_count = 0, tests_run = 0;
  febs_ctrl #(.SECT_TO(200), .ADD_LIM(150), .SUSP_MAX(50)) u_febs_ctrl (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .fl_dq_i(dq), .ready_busy_pin(rb), .fl_pins(pins));
  febs_flash_model u_febs_flash_model (.aclk, .pins, .dq, .rb);
  initial
    forever #12.5 aclk = ~aclk;
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do @(posedge aclk); while (awready !== 1'b1);
    {awvalid, wvalid} <= 2'b00;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    {rv, rr} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd
  // polling busy rather than counting cycles keeps the bench free of pin timing
  task automatic op(input logic [3:0] c);
    wr(OFS_CTRL, {28'h0, c});
    do rd(OFS_STATUS); while (rv[ST_BUSY] !== 1'b0);
  endtask : op
  task automatic t_bypass;
    rd(OFS_STATUS);
    chk("status", 32'h80, rv);
    rd(8'h20);
    chk("rresp", 2'b10, rr);
    wr(OFS_ADDR, 32'h12345);
    wr(OFS_DATA, 32'h3C);
    op(4'h2);
    op(4'h3);
    chk("seq", 40'hAA5520A03C, u_febs_flash_model.hist[39:0]);
    chk("byp", 1, rv[ST_BYP]);
    op(4'h5);
    chk("err", 1, rv[ST_ERR]);
    wr(OFS_STATUS, 32'h40);
    op(4'h4);
    chk("exit", 24'h3C9000, u_febs_flash_model.hist[23:0]);
    chk("byp", 0, rv[ST_BYP]);
  endtask : t_bypass
  task automatic t_chip;
    op(4'h5);
    chk("seq", 48'hAA5580AA5510, u_febs_flash_model.hist);
    chk("chip", 1, rv[ST_CHIP]);
    op(4'h8);
    chk("err", 1, rv[ST_ERR]);
    wr(OFS_STATUS, 32'h40);
    do rd(OFS_STATUS); while (rv[ST_CHIP] !== 1'b0);
    chk("idle", 8'h80, rv[7:0]);
    op(4'h1);
    rd(OFS_RDATA);
    chk("rdata", 32'h5A, rv);
  endtask : t_chip
  task automatic t_sect;
    wr(OFS_ADDR, 32'hE0000);
    op(4'h6);
    chk("win", 1, rv[ST_WIN]);
    chk("sector", 7'h70, u_febs_flash_model.sect_sel);
    op(4'h7);
    chk("add", 1, rv[ST_WIN] & ~rv[ST_ERR]);
    op(4'h8);
    chk("susp", 2'b10, {rv[ST_SUSP], rv[ST_WIN]});
    op(4'hB);
    chk("autosel", 2'b10, {rv[ST_SUSP], rv[ST_ERR]});
    op(4'h9);
    chk("resume", 0, rv[ST_SUSP]);
    op(4'hC);
    chk("abort", 1, rv[ST_ABRT]);
    op(4'h6);
    op(4'hA);
    chk("reset", 0, rv[ST_SECT:ST_WIN]);
  endtask : t_sect
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_bypass;
    t_chip;
    t_sect;
    complete_run;
  end
  initial
  begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    complete_run;
  end
endmodule : tb_flash_erase_bypass_sequencer
`default_nettype wire
